// file: verilog/snp_cc_end.sv
`timescale 1ns/100ps
`include "snp_defines.svh"
// ********************************************************************
// Cache controller end: inbound invalidate and shared intervention
// ********************************************************************
module snp_cc_end #(
	parameter int DATA_W = 128
) (
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	snp_bus_if.cc                  bus,
	input  wire logic              op_valid,
	input  wire logic              op_shared,
	input  wire logic [39:7]       op_addr,
	input  wire logic [1:0]        op_way,
	input  wire logic              line_dirty,
	input  wire logic              line_exclusive,
	output logic                   op_taken,
	output logic                   op_done,
	output logic                   data_keep,
	output logic                   rd_valid,
	output logic [DATA_W-1:0]      rd_data
);
	// ****************************************************************
	// State
	// ****************************************************************
	snp_pkg::snp_cc_state_type state;      // Sequencer state
	snp_pkg::snp_cc_state_type next_state; // Sequencer next state
	logic [3:0]                step;       // Owned-state index
	logic [3:0]                next_step;  // Next owned-state index
	logic                      shared;     // Current op is intervention
	logic [39:7]               addr;       // Current sector address
	logic [1:0]                way;        // Current set
	logic                      hit_seen;   // Queue hit this attempt
	logic                      retry;      // Restart after queue drain
	logic                      next_retry; // Next restart flag
	logic                      take;       // Accept a new op now
	logic                      last_step;  // Final owned state
	logic                      clean_excl; // Line may turn shared
	logic [39:5]               nst_word;   // New state on address field
	logic [1:0]                inv_line;   // Line within sector

	// Last step; a queue hit cuts the intervention short
	assign last_step = shared ?
		(step == `SNP_SI_LAST || (step == `SNP_SI_EQ && hit_seen)) :
		(step == `SNP_IV_LAST);

	// Limitation: needs the tag read result by the last step
	assign clean_excl = line_exclusive && !line_dirty;

	// Line index of each invalidate address
	assign inv_line = shared ?
		((step == `SNP_SI_BYPASS) ? 2'h0 : 2'(step - `SNP_SI_IV_BASE)) :
		2'(step - 4'h1);

	// New state word, zero above the state bits
	always_comb begin
		nst_word = '0;
		nst_word[`SNP_TRA_LSB +: `SNP_ST_W] =
			shared ? `SNP_ST_SHARED : `SNP_ST_INVALID;
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Next state, step and accept
	always_comb begin
		next_state = state;
		next_step = step;
		next_retry = retry;
		take = 1'b0;
		unique case (state)
			snp_pkg::CC_IDLE: begin
				if (op_valid) begin
					take = 1'b1;
					next_state = snp_pkg::CC_REQ;
				end
			end
			snp_pkg::CC_REQ: begin
				// [R4] Wait for release, however long
				if (!bus.processor_bus_release_n) begin
					next_state = snp_pkg::CC_RUN;
					next_step = '0;
				end
			end
			snp_pkg::CC_RUN: begin
				if (!last_step) begin
					next_step = step + 4'h1;
				end else if (shared && hit_seen) begin
					// [R12] Hand back, restart after draining
					next_state = snp_pkg::CC_DROP;
					next_retry = 1'b1;
				end else if (op_valid) begin
					// [R3] Chain without giving the bus back
					take = 1'b1;
					next_step = '0;
				end else begin
					// [R22] Give the bus back when done
					next_state = snp_pkg::CC_DROP;
					next_retry = 1'b0;
				end
			end
			snp_pkg::CC_DROP: begin
				// Wait for the grant to drop before asking again
				if (bus.processor_bus_release_n) begin
					next_state = retry ? snp_pkg::CC_REQ : snp_pkg::CC_IDLE;
				end
			end
		endcase
	end

	// State registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= snp_pkg::CC_IDLE;
			step <= '0;
			retry <= 1'b0;
		end else begin
			state <= next_state;
			step <= next_step;
			retry <= next_retry;
		end
	end

	// Operation latch
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			shared <= 1'b0;
			addr <= '0;
			way <= '0;
		end else if (take) begin
			shared <= op_shared;
			addr <= op_addr;
			way <= op_way;
		end
	end

	// Queue hit capture, cleared per attempt
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			hit_seen <= 1'b0;
		end else if (state != snp_pkg::CC_RUN) begin
			if (state == snp_pkg::CC_REQ) begin
				hit_seen <= 1'b0;
			end
		end else if (take) begin
			hit_seen <= 1'b0;
		end else if (shared && step < `SNP_SI_EQ) begin
			// [R10] Either queue may hit
			hit_seen <= hit_seen || !bus.even_queue_hit_n ||
				!bus.odd_queue_hit_n;
		end
	end

	// [R22] Request follows the sequencer
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bus.controller_bus_request_n <= 1'b1;
		end else begin
			bus.controller_bus_request_n <=
				!(next_state == snp_pkg::CC_REQ ||
				next_state == snp_pkg::CC_RUN);
		end
	end

	// ****************************************************************
	// Bus drive
	// ****************************************************************
	// Outputs for each owned state; idle values elsewhere
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bus.func <= `SNP_FN_NOP;
			bus.transfer_address_field <= '0;
			bus.cache_ram_address <= '0;
			bus.stream_addr_valid <= 1'b0;
			bus.bypass_n <= 1'b1;
			bus.tag_state_write_strobe_n <= 1'b1;
			bus.tag_state_read_strobe_n <= 1'b1;
			bus.tag_output_enable_n <= 1'b1;
			bus.way_select <= '0;
		end else begin
			bus.func <= `SNP_FN_NOP;
			bus.transfer_address_field <= '0;
			bus.cache_ram_address <= '0;
			bus.stream_addr_valid <= 1'b0;
			bus.bypass_n <= 1'b1;
			bus.tag_state_write_strobe_n <= 1'b1;
			bus.tag_state_read_strobe_n <= 1'b1;
			bus.tag_output_enable_n <= 1'b1;
			bus.way_select <= '0;
			if (state == snp_pkg::CC_RUN && !shared) begin
				// [R2] Tag write first, then invalidates
				if (step == '0) begin
					// [R5] New state with no-operation code
					bus.transfer_address_field <= nst_word;
				end else begin
					// [R7] Four line addresses, one sector
					bus.func <= `SNP_FN_INVAL;
					bus.transfer_address_field <= {addr, inv_line};
				end
				// [R6] Strobe and set two clocks later
				if (step == `SNP_IV_TAG_STATE_WRITE_STROBE_N) begin
					bus.tag_state_write_strobe_n <= 1'b0;
					bus.way_select <= way;
				end
			end else if (state == snp_pkg::CC_RUN) begin
				// [R9] Pipelined intervention operations
				if (step < `SNP_SI_EQ) begin
					// [R14] Eight streaming addresses
					bus.cache_ram_address <= {addr[21:7], step[2:0]};
					bus.stream_addr_valid <= 1'b1;
				end
				if (step == '0) begin
					// Read address for the queue compare
					bus.transfer_address_field <= {addr, 2'h0};
				end
				if (step == `SNP_SI_BYPASS) begin
					// [R19] Bypass in second state
					bus.bypass_n <= 1'b0;
				end
				if (step == `SNP_SI_BYPASS ||
					(step >= `SNP_SI_IV_FIRST && step < `SNP_SI_NST)) begin
					bus.func <= `SNP_FN_INVAL;
					bus.transfer_address_field <= {addr, inv_line};
				end
				if (step == `SNP_SI_RD_FIRST || step == `SNP_SI_RD_LAST) begin
					// [R15] [R20] Combined read, result later
					bus.func <= `SNP_FN_RD_BOTH;
				end
				// [R16] Old state read, then enable
				if (step == `SNP_SI_TAG_STATE_READ_STROBE_N) begin
					bus.tag_state_read_strobe_n <= 1'b0;
				end
				if (step == `SNP_SI_TOE) begin
					bus.tag_output_enable_n <= 1'b0;
				end
				if (step == `SNP_SI_NST) begin
					// [R17] Tag-only state with code zero
					bus.transfer_address_field <= nst_word;
				end
				if (step == `SNP_SI_EQ) begin
					// [R18] Honoured only if this is last
					bus.func <= `SNP_FN_EMPTYQ;
				end
				// [R11] Commit only for clean exclusive
				if (step == `SNP_SI_LAST && clean_excl) begin
					bus.tag_state_write_strobe_n <= 1'b0;
					bus.way_select <= way;
				end
			end
		end
	end

	// ****************************************************************
	// User side
	// ****************************************************************
	// Completion and data forwarding
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			op_taken <= 1'b0;
			op_done <= 1'b0;
			data_keep <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= '0;
		end else begin
			op_taken <= take;
			op_done <= state == snp_pkg::CC_RUN && last_step &&
				!(shared && hit_seen);
			// [R11] Data worth keeping only dirty exclusive
			data_keep <= state == snp_pkg::CC_RUN && last_step &&
				shared && !hit_seen && line_dirty && line_exclusive;
			// [R13] Data follows address by fixed latency
			// [R8] Nothing captured for invalidates
			rd_valid <= bus.store_data_valid && shared && !hit_seen;
			rd_data <= bus.store_data;
		end
	end
endmodule

// file: verilog/snp_defines.svh
`ifndef SNP_DEFINES_SVH
`define SNP_DEFINES_SVH
// ********************************************************************
// Summary of operation
// [R1] Function 10 invalidates one 32-byte line
// [R2] Invalidate: tag state write, then line invalidates
// [R3] Pending operations may keep the bus owned
// [R4] Request, then wait for release, up to 1024; snp_cc_end waits in CC_REQ with no limit
// [R5] First owned state: new state, function zero
// [R6] Write strobe and set select two clocks later
// [R7] Four invalidates cover one 128-byte sector
// [R8] Write data bus meaningless during invalidate
// [R9] Intervention: read, compare, tag read, write, invalidate
// [R10] Queue compare on bits 17:7, both queues
// [R11] Shared only when clean exclusive, else unchanged
// [R12] Queue hit: discard data, keep state, hand back
// [R13] Read data seven clocks after first address
// [R14] Eight streaming addresses, 128 bits each
// [R15] Combined tag read in third, fourth states
// [R16] Old state read clock 6, new state eighth
// [R17] Tag-only transfers carry function zero
// [R18] Empty-queue code honoured only in last state
// [R19] Bypass asserted in second intervention state
// [R20] Function codes: 0,2,3,5,6,7 as listed
// [R21] Withdrawn request: exit state, then empty queue
// [R22] Withdraw request after final operation
// ********************************************************************

// ********************************************************************
// Function field codes
// ********************************************************************
`define SNP_FN_NOP      4'h0
`define SNP_FN_INTR     4'h2
`define SNP_FN_EMPTYQ   4'h3
`define SNP_FN_RD_EVEN  4'h5
`define SNP_FN_RD_ODD   4'h6
`define SNP_FN_RD_BOTH  4'h7
`define SNP_FN_INVAL    4'ha

// ********************************************************************
// Sequence steps (step 0 is the first owned state)
// ********************************************************************
`define SNP_IV_TAG_STATE_WRITE_STROBE_N     4'h2
`define SNP_IV_LAST     4'h4
`define SNP_SI_BYPASS   4'h1
`define SNP_SI_RD_FIRST 4'h2
`define SNP_SI_RD_LAST  4'h3
`define SNP_SI_IV_FIRST 4'h4
`define SNP_SI_TAG_STATE_READ_STROBE_N     4'h5
`define SNP_SI_TOE      4'h6
`define SNP_SI_NST      4'h7
`define SNP_SI_EQ       4'h8
`define SNP_SI_LAST     4'h9
`define SNP_SI_IV_BASE  4'h3

// ********************************************************************
// Bus fields, line states and timing
// ********************************************************************
`define SNP_TRA_LSB     5
`define SNP_ST_W        4
`define SNP_ST_INVALID  4'h0
`define SNP_ST_SHARED   4'h1
`define SNP_SAQ_HI      17
`define SNP_SAQ_LO      7
`define SNP_DATA_DELAY  7
`define SNP_REL_MAX     1024
`endif

// file: verilog/snp_pkg.sv
package snp_pkg;
	// Controller sequencing states
	typedef enum logic [1:0] {
		CC_IDLE,
		CC_REQ,
		CC_RUN,
		CC_DROP
	} snp_cc_state_type;

	// Processor view of the transfer bus
	typedef enum logic [1:0] {
		BS_RUN,
		BS_CC,
		BS_BE,
		BS_EQ
	} snp_bus_state_type;
endpackage

// file: verilog/snp_bus_if.sv
`timescale 1ns/100ps
interface snp_bus_if #(parameter int DATA_W = 128);
	logic              controller_bus_request_n; // Controller wants bus
	logic              processor_bus_release_n;  // Processor grants bus
	logic [3:0]        func;                     // Function field
	logic [39:5]       transfer_address_field;   // Address/state field
	logic [21:4]       cache_ram_address;        // Streaming address
	logic              stream_addr_valid;        // Streaming address live
	logic              bypass_n;                 // Load-to-store bypass
	logic              tag_state_write_strobe_n; // Tag state write
	logic              tag_state_read_strobe_n;  // Tag state read
	logic              tag_output_enable_n;      // Tag bus enable
	logic [1:0]        way_select;               // Set of four
	logic              even_queue_hit_n;         // Even queue hit
	logic              odd_queue_hit_n;          // Odd queue hit
	logic [DATA_W-1:0] store_data;               // Store data bus
	logic              store_data_valid;         // Store data live

	modport cc (
		output controller_bus_request_n,
		input  processor_bus_release_n,
		output func,
		output transfer_address_field,
		output cache_ram_address,
		output stream_addr_valid,
		output bypass_n,
		output tag_state_write_strobe_n,
		output tag_state_read_strobe_n,
		output tag_output_enable_n,
		output way_select,
		input  even_queue_hit_n,
		input  odd_queue_hit_n,
		input  store_data,
		input  store_data_valid
	);

	modport proc (
		input  controller_bus_request_n,
		output processor_bus_release_n,
		input  func,
		input  transfer_address_field,
		input  cache_ram_address,
		input  stream_addr_valid,
		input  bypass_n,
		input  tag_state_write_strobe_n,
		input  tag_state_read_strobe_n,
		input  tag_output_enable_n,
		input  way_select,
		output even_queue_hit_n,
		output odd_queue_hit_n,
		output store_data,
		output store_data_valid
	);
endinterface

// file: verilog/snp_saq_match.sv
`timescale 1ns/100ps
`include "snp_defines.svh"
// ********************************************************************
// Store address queue compare, one queue
// ********************************************************************
module snp_saq_match #(
	parameter int DEPTH = 4,
	parameter int TAG_W = `SNP_SAQ_HI - `SNP_SAQ_LO + 1
) (
	input  wire logic [TAG_W-1:0]       addr_tag,
	input  wire logic [DEPTH*TAG_W-1:0] entries,
	input  wire logic [DEPTH-1:0]       live,
	output logic                        match
);
	logic [DEPTH-1:0] hits; // Per-entry compare result

	// [R10] Every entry compared
	for (genvar i = 0; i < DEPTH; i++) begin : g_cmp
		assign hits[i] = live[i] &&
			(entries[i*TAG_W +: TAG_W] == addr_tag);
	end

	// Any valid entry counts
	assign match = |hits;
endmodule

// file: verilog/snp_proc_end.sv
`timescale 1ns/100ps
`include "snp_defines.svh"
// ********************************************************************
// Processor end of the coherence transfer bus
// ********************************************************************
module snp_proc_end #(
	parameter int DATA_W    = 128,
	parameter int SAQ_DEPTH = 4,
	parameter int TAG_W     = `SNP_SAQ_HI - `SNP_SAQ_LO + 1
) (
	input  wire logic                       core_clk,
	input  wire logic                       sys_rst,
	snp_bus_if.proc                         bus,
	input  wire logic                       transfer_busy,
	input  wire logic                       queue_empty,
	input  wire logic [SAQ_DEPTH*TAG_W-1:0] even_entries,
	input  wire logic [SAQ_DEPTH-1:0]       even_live,
	input  wire logic [SAQ_DEPTH*TAG_W-1:0] odd_entries,
	input  wire logic [SAQ_DEPTH-1:0]       odd_live,
	input  wire logic [DATA_W-1:0]          load_data,
	output logic                            dcache_inval,
	output logic [39:5]                     dcache_inval_addr,
	output logic                            queue_drain
);
	localparam int DLY = `SNP_DATA_DELAY;

	snp_pkg::snp_bus_state_type bstate;    // Bus ownership state
	logic                       eq_flag;   // Empty-queue code seen last
	logic                       stream_d;  // Streaming valid, delayed
	logic                       bypass_on; // Bypass seen this tenure
	logic [DLY-2:0]             pipe;      // Read latency line
	logic                       even_m;    // Even queue compare
	logic                       odd_m;     // Odd queue compare
	logic                       first_adr; // First streaming address
	assign first_adr = bus.stream_addr_valid && !stream_d;

	// ****************************************************************
	// Queue compare
	// ****************************************************************
	snp_saq_match #(.DEPTH(SAQ_DEPTH), .TAG_W(TAG_W)) u_even (
		.addr_tag (bus.transfer_address_field[`SNP_SAQ_HI:`SNP_SAQ_LO]),
		.entries  (even_entries),
		.live     (even_live),
		.match    (even_m)
	);

	snp_saq_match #(.DEPTH(SAQ_DEPTH), .TAG_W(TAG_W)) u_odd (
		.addr_tag (bus.transfer_address_field[`SNP_SAQ_HI:`SNP_SAQ_LO]),
		.entries  (odd_entries),
		.live     (odd_live),
		.match    (odd_m)
	);

	// ****************************************************************
	// Bus ownership
	// ****************************************************************
	// Release only after own transfers finish
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bstate <= snp_pkg::BS_RUN;
			bus.processor_bus_release_n <= 1'b1;
			eq_flag <= 1'b0;
		end else begin
			unique case (bstate)
				snp_pkg::BS_RUN: begin
					// [R4] Grant on request
					if (!bus.controller_bus_request_n && !transfer_busy) begin
						bstate <= snp_pkg::BS_CC;
						bus.processor_bus_release_n <= 1'b0;
					end
				end
				snp_pkg::BS_CC: begin
					// [R18] Code counts only in last state
					if (bus.controller_bus_request_n) begin
						bstate <= snp_pkg::BS_BE;
						bus.processor_bus_release_n <= 1'b1;
						eq_flag <= (bus.func == `SNP_FN_EMPTYQ);
					end
				end
				snp_pkg::BS_BE: begin
					// [R21] Exit, then empty queue
					bstate <= eq_flag ? snp_pkg::BS_EQ : snp_pkg::BS_RUN;
				end
				snp_pkg::BS_EQ: begin
					// Stay until the store queue drains
					if (queue_empty) begin
						bstate <= snp_pkg::BS_RUN;
						eq_flag <= 1'b0;
					end
				end
			endcase
		end
	end

	// Drain indicator while in the empty-queue state
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			queue_drain <= 1'b0;
		end else begin
			queue_drain <= (bstate == snp_pkg::BS_BE && eq_flag) ||
				(bstate == snp_pkg::BS_EQ && !queue_empty);
		end
	end

	// ****************************************************************
	// Function decode
	// ****************************************************************
	// [R1] Line invalidate; zero and others ignored
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dcache_inval <= 1'b0;
			dcache_inval_addr <= '0;
		end else begin
			dcache_inval <= (bstate == snp_pkg::BS_CC) &&
				(bus.func == `SNP_FN_INVAL);
			dcache_inval_addr <= bus.transfer_address_field;
		end
	end

	// [R10] Compare on the first streaming address
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stream_d <= 1'b0;
			bus.even_queue_hit_n <= 1'b1;
			bus.odd_queue_hit_n <= 1'b1;
		end else begin
			stream_d <= bus.stream_addr_valid;
			bus.even_queue_hit_n <= !(first_adr && even_m &&
				bstate == snp_pkg::BS_CC);
			bus.odd_queue_hit_n <= !(first_adr && odd_m &&
				bstate == snp_pkg::BS_CC);
		end
	end

	// ****************************************************************
	// Read data path
	// ****************************************************************
	// [R13] Fixed latency from address to data
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pipe <= '0;
			bypass_on <= 1'b0;
			bus.store_data_valid <= 1'b0;
			bus.store_data <= '0;
		end else begin
			pipe <= {pipe[DLY-3:0], bus.stream_addr_valid};
			// [R19] [R12] Bypass on; hit aborts data
			if (!bus.even_queue_hit_n || !bus.odd_queue_hit_n) begin
				bypass_on <= 1'b0;
			end else if (!bus.bypass_n) begin
				bypass_on <= 1'b1;
			end else if (!pipe[DLY-2] && bstate != snp_pkg::BS_CC) begin
				bypass_on <= 1'b0;
			end
			bus.store_data_valid <= pipe[DLY-2] && bypass_on;
			bus.store_data <= load_data;
		end
	end
endmodule

// file: verif/snp_properties.sv
`timescale 1ns/100ps
// ********
// Link rules watched on the shared bus
// ********
module snp_properties (
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic        controller_bus_request_n,
	input wire logic        processor_bus_release_n,
	input wire logic [3:0]  func,
	input wire logic [39:5] transfer_address_field,
	input wire logic [21:4] cache_ram_address,
	input wire logic        stream_addr_valid,
	input wire logic        bypass_n,
	input wire logic        tag_state_write_strobe_n,
	input wire logic        tag_state_read_strobe_n,
	input wire logic        tag_output_enable_n,
	input wire logic [1:0]  way_select,
	input wire logic        even_queue_hit_n,
	input wire logic        odd_queue_hit_n,
	input wire logic        store_data_valid
);
	// One domain: one clock and reset for all
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	legal_func_a: assert property (
		func < 4'hb && !(func inside {4'h1, 4'h4, 4'h8, 4'h9}))
		else $error("reserved function code");
	grant_order_a: assert property (
		$fell(processor_bus_release_n) |-> !$past(controller_bus_request_n))
		else $error("grant without request");
	inval_seq_a: assert property (
		$fell(processor_bus_release_n) ##3 bypass_n |-> ($past(func) == 4'h0
		&& func == 4'ha) ##1 (!tag_state_write_strobe_n && func == 4'ha)
		##1 func == 4'ha ##1 func == 4'ha) else $error("invalidate steps");
	way_idle_a: assert property (
		tag_state_write_strobe_n |-> way_select == 2'h0)
		else $error("set select outside strobe");
	bypass_a: assert property (
		!bypass_n |-> (func == 4'ha && stream_addr_valid &&
		cache_ram_address[6:4] == 3'h1) ##1 (bypass_n && func == 4'h7)
		##1 func == 4'h7) else $error("bypass step wrong");
	old_state_a: assert property (
		!bypass_n |-> ##4 !tag_state_read_strobe_n ##1 !tag_output_enable_n
		##1 (func == 4'h0 && transfer_address_field[8:5] == 4'h1))
		else $error("state steps wrong");
	stream_len_a: assert property (
		$rose(stream_addr_valid) |-> stream_addr_valid [*8] ##1
		!stream_addr_valid) else $error("streaming count wrong");
	data_delay_a: assert property (
		$rose(stream_addr_valid) ##1 (even_queue_hit_n && odd_queue_hit_n)
		|-> ##6 $rose(store_data_valid)) else $error("read data late");
	hit_exit_a: assert property (
		$fell(even_queue_hit_n && odd_queue_hit_n) |-> ##7 (func == 4'h3 &&
		controller_bus_request_n) ##1 tag_state_write_strobe_n)
		else $error("queue hit exit wrong");
	release_back_a: assert property (
		$rose(controller_bus_request_n) |-> ##[1:2] processor_bus_release_n)
		else $error("bus not handed back");
	cover property ($fell(processor_bus_release_n));
	cover property (!bypass_n);
	cover property ($fell(even_queue_hit_n));
	cover property ($fell(odd_queue_hit_n));
endmodule

// file: verif/tb_snoop_invalidate_intervention.sv
`timescale 1ns/100ps
// ********
// Both link ends, user sides driven
// ********
module tb_snoop_invalidate_intervention;
	logic         core_clk;
	logic         sys_rst        = 1'h1;
	logic         op_valid       = 1'h0;
	logic         op_shared      = 1'h0;
	logic [39:7]  op_addr        = '0;
	logic [1:0]   op_way         = '0;
	logic         line_dirty     = 1'h0;
	logic         line_exclusive = 1'h0;
	logic         transfer_busy  = 1'h0;
	logic         queue_empty    = 1'h1;
	logic [43:0]  even_entries   = '0;
	logic [43:0]  odd_entries    = '0;
	logic [3:0]   even_live      = '0;
	logic [3:0]   odd_live       = '0;
	logic [127:0] load_data      = '0;
	logic [127:0] rd_data;
	logic [39:5]  dcache_inval_addr;
	logic         op_taken, op_done, data_keep, rd_valid, dcache_inval;
	logic         queue_drain;
	int           seed = 32'h71589908, failures = 0, n_checks = 0;
	// Expected results, oldest first
	logic [127:0] q_inv[$], q_done[$], q_rd[$], q_way[$];

	snp_bus_if link ();
	snp_cc_end i_snp_cc_end (
		.core_clk(core_clk), .sys_rst(sys_rst), .bus(link.cc),
		.op_valid(op_valid), .op_shared(op_shared), .op_addr(op_addr),
		.op_way(op_way), .line_dirty(line_dirty),
		.line_exclusive(line_exclusive), .op_taken(op_taken),
		.op_done(op_done), .data_keep(data_keep), .rd_valid(rd_valid),
		.rd_data(rd_data));
	snp_proc_end i_snp_proc_end (
		.core_clk(core_clk), .sys_rst(sys_rst), .bus(link.proc),
		.transfer_busy(transfer_busy), .queue_empty(queue_empty),
		.even_entries(even_entries), .even_live(even_live),
		.odd_entries(odd_entries), .odd_live(odd_live),
		.load_data(load_data), .dcache_inval(dcache_inval),
		.dcache_inval_addr(dcache_inval_addr), .queue_drain(queue_drain));
	snp_properties i_snp_properties (
		.core_clk(core_clk), .sys_rst(sys_rst),
		.controller_bus_request_n(link.controller_bus_request_n),
		.processor_bus_release_n(link.processor_bus_release_n),
		.func(link.func),
		.transfer_address_field(link.transfer_address_field),
		.cache_ram_address(link.cache_ram_address),
		.stream_addr_valid(link.stream_addr_valid),
		.bypass_n(link.bypass_n),
		.tag_state_write_strobe_n(link.tag_state_write_strobe_n),
		.tag_state_read_strobe_n(link.tag_state_read_strobe_n),
		.tag_output_enable_n(link.tag_output_enable_n),
		.way_select(link.way_select),
		.even_queue_hit_n(link.even_queue_hit_n),
		.odd_queue_hit_n(link.odd_queue_hit_n),
		.store_data_valid(link.store_data_valid));

	initial begin
		core_clk = 1'h0;
		forever #25 core_clk = ~core_clk;
	end

	// Random processor stalls, about one cycle in four, delay some grants
	always @(negedge core_clk)
		transfer_busy <= ($random(seed) & 3) == 0;

	task automatic final_report();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Oldest note against what came out; none left reads as unknown
	task automatic check(input string nm, ref logic [127:0] q[$],
		input logic [127:0] got);
		logic [127:0] exp;
		exp = q.size() ? q.pop_front() : 'x;
		n_checks++;
		if (exp !== got) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Bounded wait: 0 taken, 1 drain, else all notes matched
	task automatic wait_for(input int what);
		int lim = 300;
		while (!(what == 0 ? op_taken === 1'h1 : what == 1 ?
			queue_drain === 1'h1 : q_inv.size() + q_rd.size() +
			q_done.size() + q_way.size() == 0)) begin
			if (lim-- == 0) begin
				failures++;
				$display("MISMATCH wait %0d expected 1 seen 0", what);
				final_report();
			end
			@(negedge core_clk);
		end
	endtask

	// Issue one operation and note what it must give
	task automatic do_op(input logic sh, d, e, input int passes,
		input logic [39:7] a);
		@(negedge core_clk);
		op_shared = sh;
		op_addr = a;
		op_way = 2'($random(seed));
		line_dirty = d;
		line_exclusive = e;
		load_data = {$random(seed), $random(seed), $random(seed), $random(seed)};
		op_valid = 1'h1;
		q_done.push_back(128'(sh & d & e));
		// Strobe only when invalidating or clean exclusive
		if (!sh || (!d && e))
			q_way.push_back(128'(op_way));
		for (int k = 0; k < 4 * passes; k++)
			q_inv.push_back(128'({a, k[1:0]}));
		for (int k = 0; k < 8 * sh; k++)
			q_rd.push_back(load_data);
		wait_for(0);
		op_valid = 1'h0;
	endtask

	// Result watcher
	always @(negedge core_clk) begin
		if (dcache_inval === 1'h1)
			check("inval_addr", q_inv, 128'(dcache_inval_addr));
		if (rd_valid === 1'h1)
			check("rd_data", q_rd, rd_data);
		if (op_done === 1'h1)
			check("data_keep", q_done, 128'(data_keep));
		if (link.tag_state_write_strobe_n === 1'h0)
			check("way_select", q_way, 128'(link.way_select));
	end

	initial begin
		logic [39:7] a;
		repeat (3) @(negedge core_clk);
		sys_rst = 1'h0;
		// Two invalidates on one tenure
		do_op(1'h0, 1'h0, 1'h0, 1, 33'($random(seed)));
		do_op(1'h0, 1'h1, 1'h1, 1, 33'($random(seed)));
		wait_for(2);
		// Each dirty and exclusive mix, a live entry that misses
		for (int m = 0; m < 4; m++) begin
			a = 33'({$random(seed), $random(seed)});
			even_entries[21:11] = ~a[17:7];
			even_live = 4'h2;
			do_op(1'h1, m[1], m[0], 1, a);
			wait_for(2);
		end
		// Hit in even then odd queue: hand back, drain, restart
		for (int h = 0; h < 2; h++) begin
			a = 33'({$random(seed), $random(seed)});
			even_entries[10:0] = a[17:7];
			odd_entries[10:0] = a[17:7];
			{odd_live, even_live} = h ? 8'h10 : 8'h01;
			queue_empty = 1'h0;
			do_op(1'h1, 1'h1, 1'h1, 2, a);
			wait_for(1);
			{odd_live, even_live} = 8'h00;
			queue_empty = 1'h1;
			wait_for(2);
		end
		repeat (20) @(negedge core_clk);
		final_report();
	end
endmodule
